/* File: src/psvt_pkg.sv */
// Constants, field layout and state type for the status and input-voltage slice.
// Assumes a 250 MHz core clock and a command engine that decodes the bus.
package psvt_pkg;

  localparam int NDEV = 4;
  localparam int DEV_W = 2;
  localparam int CTRL_DEV = 0;

  localparam logic [7:0] CMD_OTHER = 8'h7f;
  localparam logic [7:0] CMD_VENDOR = 8'h80;
  localparam logic [7:0] CMD_VIN = 8'h88;
  localparam logic [7:0] PHASE_ALL = 8'hff;

  // Other-status layout
  localparam int OTH_FIRST_BIT = 0;

  // Vendor status byte layout
  localparam int VS_POR_BIT = 7;
  localparam int VS_SELF_BIT = 6;
  localparam int VS_RESTART_BIT = 3;
  localparam int VS_BCX_BIT = 2;
  localparam int VS_SYNC_BIT = 1;

  // Packed latched flags kept per device
  localparam int VF_POR = 3;
  localparam int VF_RESTART = 2;
  localparam int VF_BCX = 1;
  localparam int VF_SYNC = 0;

  // Signed linear word fields
  localparam int LIN_EXP_LSB = 11;
  localparam int LIN_MAN_MSB = 10;

  // Values after reset
  localparam logic FIRST_RST = 1'b0;
  localparam logic [3:0] VFLAG_RST = 4'h0;
  localparam logic [15:0] VIN_RST = 16'h0000;
  localparam logic [15:0] RDATA_RST = 16'h0000;

  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int VIN_REFRESH_MS = 1;
  localparam int VIN_REFRESH_CYC_DEF = (VIN_REFRESH_MS * 1000000000) / CLK_PERIOD_PS;
  localparam int TICK_W = 18;
  localparam int SYNC_TIMEOUT_NS = 1000;
  localparam int SYNC_TIMEOUT_CYC = (SYNC_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
  localparam int IDLE_W = 10;

  typedef struct packed {
    logic [NDEV-1:0][3:0] vflag;
    logic first;
    logic alert;
    logic [NDEV-1:0][15:0] vin;
    logic [TICK_W-1:0] tick;
    logic [IDLE_W-1:0] sync_idle;
    logic sync_prev;
    logic [15:0] rdata;
    logic rvalid;
    logic hit;
    logic ivc;
    logic other_sum;
    logic vendor_sum;
  } psvt_state_t;

endpackage : psvt_pkg

/* File: src/psvt_regs.sv */
// Other-status, vendor status and input-voltage reading commands.
// Assumes a command engine on the same clock hands over decoded reads and
// writes one per request, and that flag sources run on the same clock.
`timescale 1ns/1ps
module psvt_regs #(
  parameter int VIN_REFRESH_CYC = psvt_pkg::VIN_REFRESH_CYC_DEF
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Command request from the bus engine
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [7:0] cmd_wdata_i,
  input wire logic [7:0] phase_i,
  input wire logic clear_faults_i,
  // Power-on checks of the controller
  input wire logic trim_check_bad_i,
  input wire logic store_checksum_bad_i,
  input wire logic strap_detect_bad_i,
  input wire logic self_check_busy_i,
  input wire logic [psvt_pkg::NDEV-1:0] follower_expected_i,
  input wire logic [psvt_pkg::NDEV-1:0] follower_responded_i,
  // Per-device fault events, one-cycle pulses
  input wire logic [psvt_pkg::NDEV-1:0] output_restart_event_i,
  input wire logic [psvt_pkg::NDEV-1:0] back_channel_fault_i,
  input wire logic [psvt_pkg::NDEV-1:0] sync_fault_i,
  // Frequency sync input pin and its watchdog enable
  input wire logic sync_clk_i,
  input wire logic sync_check_en_i,
  // Shared alert line and mask bits from the alert mask command
  input wire logic alert_line_n_i,
  input wire logic [7:0] alert_mask_i,
  // Measured rails, one word per device, signed linear format
  input wire logic [psvt_pkg::NDEV-1:0][15:0] power_input_rail_i,
  // Answers
  output logic [15:0] rdata_o,
  output logic rvalid_o,
  output logic cmd_hit_o,
  output logic ivc_set_o,
  output logic other_summary_o,
  output logic vendor_summary_o,
  output logic alert_req_o
);

  import psvt_pkg::*;

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(VIN_REFRESH_CYC - 1);
  localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(SYNC_TIMEOUT_CYC - 1);
  localparam logic [IDLE_W-1:0] IDLE_MAX = IDLE_W'(SYNC_TIMEOUT_CYC);

  psvt_state_t s_r;
  psvt_state_t s_nxt;

  logic [1:0] pin_q;
  logic sync_lvl;
  logic alert_line_n;

  // Sync clock idles low, the alert line idles high
  psvt_sync #(
    .W(2),
    .RST_VAL(2'h2)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i({alert_line_n_i, sync_clk_i}),
    .q_o(pin_q)
  );

  assign sync_lvl = pin_q[0];
  assign alert_line_n = pin_q[1];

  // Places the latched flags and the live bit into the vendor byte
  function automatic logic [7:0] vendor_byte(input logic [3:0] f, input logic live);
    logic [7:0] b;
    b = 8'h00;
    b[VS_POR_BIT] = f[VF_POR];
    b[VS_SELF_BIT] = live;
    b[VS_RESTART_BIT] = f[VF_RESTART];
    b[VS_BCX_BIT] = f[VF_BCX];
    b[VS_SYNC_BIT] = f[VF_SYNC];
    return b;
  endfunction : vendor_byte

  // Gathers the clear mask of a vendor write in flag order
  function automatic logic [3:0] vendor_clear(input logic [7:0] w);
    logic [3:0] c;
    c = 4'h0;
    c[VF_POR] = w[VS_POR_BIT];
    c[VF_RESTART] = w[VS_RESTART_BIT];
    c[VF_BCX] = w[VS_BCX_BIT];
    c[VF_SYNC] = w[VS_SYNC_BIT];
    return c;
  endfunction : vendor_clear

  // Request decode, shared by the read answer and the write side effects
  logic rd_req;
  logic wr_req;
  logic wr_other;
  logic wr_vendor;

  assign rd_req = cmd_valid_i & ~cmd_write_i;
  assign wr_req = cmd_valid_i & cmd_write_i;
  assign wr_other = wr_req & (cmd_code_i == CMD_OTHER);
  assign wr_vendor = wr_req & (cmd_code_i == CMD_VENDOR);

  logic phase_all;
  logic phase_ok;
  logic [DEV_W-1:0] sel_dev;

  // Phase FFh addresses the loop controller for reads and all devices for clears
  assign phase_all = (phase_i == PHASE_ALL);
  // Vendor and voltage reads at phases beyond the stack return zero; vendor writes there clear nothing
  assign phase_ok = phase_all | (phase_i < 8'(NDEV));
  assign sel_dev = phase_all ? DEV_W'(CTRL_DEV) : phase_i[DEV_W-1:0];

  logic por_bad;
  logic self_live;

  assign por_bad = trim_check_bad_i | store_checksum_bad_i | strap_detect_bad_i;
  // Live, never stored: reflects the checks as they stand now
  assign self_live = self_check_busy_i |
    (|(follower_expected_i & ~follower_responded_i));

  logic sync_edge;
  logic sync_timeout;

  // Watchdog on the sync input: missing edges while enabled count as a fault
  assign sync_edge = sync_lvl & ~s_r.sync_prev;
  // Fires once per outage, as the idle count parks at its end value
  assign sync_timeout = sync_check_en_i & ~sync_edge & (s_r.sync_idle == IDLE_LAST);

  // Alert mask and write data, both gathered into flag order
  logic [3:0] alert_mask_f;
  logic [3:0] wr_clr;

  assign alert_mask_f = vendor_clear(alert_mask_i);
  // Unsupported positions drop out here, so writing them has no effect
  assign wr_clr = vendor_clear(cmd_wdata_i);

  logic [NDEV-1:0][3:0] dev_set;
  logic [NDEV-1:0][3:0] dev_clr;
  logic [NDEV-1:0][3:0] dev_next;
  logic [NDEV-1:0] dev_wr;
  logic [NDEV-1:0] dev_alert;

  // One slice per stacked device; the latched power-on checks and the sync
  // watchdog belong to the loop controller only
  for (genvar g = 0; g < NDEV; g++) begin : g_dev
    localparam logic IS_CTRL = (g == CTRL_DEV);

    // Phase FFh clears every device, a numbered phase only its own
    assign dev_wr[g] = wr_vendor & (phase_all | (phase_ok & (sel_dev == DEV_W'(g))));

    assign dev_set[g][VF_POR] = IS_CTRL & por_bad;
    assign dev_set[g][VF_RESTART] = output_restart_event_i[g];
    assign dev_set[g][VF_BCX] = back_channel_fault_i[g];
    assign dev_set[g][VF_SYNC] = sync_fault_i[g] | (IS_CTRL & sync_timeout);

    // Clear-faults reaches every device whatever the phase
    assign dev_clr[g] = clear_faults_i ? 4'hf : (dev_wr[g] ? wr_clr : 4'h0);

    // A set in the clearing cycle wins so that no event is lost
    assign dev_next[g] = (s_r.vflag[g] & ~dev_clr[g]) | dev_set[g];
    assign dev_alert[g] = |(dev_next[g] & ~alert_mask_f);
  end

  logic alert_rise;
  logic first_set;
  logic first_clr;

  // First to alert: our request rises while the shared line is still idle
  assign alert_rise = (|dev_alert) & ~s_r.alert;
  assign first_set = alert_rise & alert_line_n;
  // Not alertable itself; cleared only by writing one or by clear-faults
  assign first_clr = clear_faults_i | (wr_other & cmd_wdata_i[OTH_FIRST_BIT]);

  always_comb begin
    s_nxt = s_r;

    // Edge history and idle count of the sync watchdog
    s_nxt.sync_prev = sync_lvl;
    if (!sync_check_en_i || sync_edge) begin
      s_nxt.sync_idle = '0;
    end else if (s_r.sync_idle != IDLE_MAX) begin
      s_nxt.sync_idle = s_r.sync_idle + IDLE_W'(1);
    end

    // Readings are snapshots so a read never sees a half-updated word
    if (s_r.tick == TICK_LAST) begin
      s_nxt.tick = '0;
      s_nxt.vin = power_input_rail_i;
    end else begin
      s_nxt.tick = s_r.tick + TICK_W'(1);
    end

    // Latched flags and the alert request they raise
    s_nxt.vflag = dev_next;
    s_nxt.alert = |dev_alert;
    s_nxt.first = (s_r.first & ~first_clr) | first_set;

    // Summaries follow the bits they cover, both on set and on clear
    s_nxt.other_sum = s_nxt.first;
    s_nxt.vendor_sum = phase_ok & (|dev_next[sel_dev]);

    // Command answers, one cycle after the request
    s_nxt.rvalid = 1'b0;
    s_nxt.hit = 1'b0;
    s_nxt.ivc = 1'b0;
    if (rd_req) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = RDATA_RST;
      case (cmd_code_i)
        CMD_OTHER: begin
          s_nxt.hit = 1'b1;
          s_nxt.rdata = {15'h0000, s_r.first};
        end
        CMD_VENDOR: begin
          s_nxt.hit = 1'b1;
          if (phase_ok) begin
            s_nxt.rdata = {8'h00, vendor_byte(s_r.vflag[sel_dev], self_live)};
          end
        end
        CMD_VIN: begin
          s_nxt.hit = 1'b1;
          // Word passes through whole: exponent over mantissa as measured
          if (phase_ok) begin
            s_nxt.rdata = s_r.vin[sel_dev];
          end
        end
        default: begin
          s_nxt.rvalid = 1'b0;
        end
      endcase
    end else if (wr_req) begin
      case (cmd_code_i)
        CMD_OTHER: begin
          s_nxt.hit = 1'b1;
        end
        CMD_VENDOR: begin
          s_nxt.hit = 1'b1;
        end
        CMD_VIN: begin
          s_nxt.hit = 1'b1;
          s_nxt.ivc = 1'b1;
        end
        default: begin
          s_nxt.hit = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_r.vflag <= {NDEV{VFLAG_RST}};
      s_r.first <= FIRST_RST;
      s_r.alert <= 1'b0;
      s_r.vin <= {NDEV{VIN_RST}};
      s_r.tick <= '0;
      s_r.sync_idle <= '0;
      s_r.sync_prev <= 1'b0;
      s_r.rdata <= RDATA_RST;
      s_r.rvalid <= 1'b0;
      s_r.hit <= 1'b0;
      s_r.ivc <= 1'b0;
      s_r.other_sum <= 1'b0;
      s_r.vendor_sum <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata_o = s_r.rdata;
  assign rvalid_o = s_r.rvalid;
  assign cmd_hit_o = s_r.hit;
  assign ivc_set_o = s_r.ivc;
  assign other_summary_o = s_r.other_sum;
  assign vendor_summary_o = s_r.vendor_sum;
  assign alert_req_o = s_r.alert;

endmodule : psvt_regs

/* File: src/psvt_sync.sv */
// Two-stage synchroniser for levels arriving from outside the core clock.
// Assumes the reset value matches the idle level of each input.
`timescale 1ns/1ps
module psvt_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } psvt_sync_st_t;

  psvt_sync_st_t s_r;
  psvt_sync_st_t s_nxt;

  // First stage feeds only the second stage
  always_comb begin
    s_nxt = s_r;
    s_nxt.meta = d_i;
    s_nxt.stable = s_r.meta;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_r <= {RST_VAL, RST_VAL};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q_o = s_r.stable;

endmodule : psvt_sync

/* File: tb/psvt_host.sv */
// Host controller model issuing one decoded command per call.
// Assumes the answer comes one cycle after the strobe edge.
`timescale 1ns/1ps
module psvt_host (
  input wire logic clk_i,
  input wire logic [15:0] rdata_i,
  input wire logic rvalid_i,
  output logic cmd_valid_o,
  output logic cmd_write_o,
  output logic [7:0] cmd_code_o,
  output logic [7:0] cmd_wdata_o,
  output logic [7:0] phase_o
);
  initial begin
    {cmd_valid_o, cmd_write_o, cmd_code_o, cmd_wdata_o, phase_o} = {2'h0, 16'h0, 8'hff};
  end
  task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] d,
    input logic [7:0] p, output logic [15:0] q);
    @(posedge clk_i);
    {cmd_valid_o, cmd_write_o, cmd_code_o, cmd_wdata_o, phase_o} <= {1'b1, w, c, d, p};
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    // Stale data must not look valid
    cmd_wdata_o <= ~d;
    #1;
    q = rvalid_i ? rdata_i : 16'hdead;
  endtask : xfer
endmodule : psvt_host

/* File: tb/psvt_regs_checker.sv */
// Concurrent checks on the command port of psvt_regs.
// Assumes phase and alert mask are held steady around each flag event.
`timescale 1ns/1ps
module psvt_regs_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [7:0] cmd_wdata_i,
  input wire logic [7:0] phase_i,
  input wire logic clear_faults_i,
  input wire logic trim_check_bad_i,
  input wire logic store_checksum_bad_i,
  input wire logic strap_detect_bad_i,
  input wire logic self_check_busy_i,
  input wire logic [3:0] output_restart_event_i,
  input wire logic [3:0] back_channel_fault_i,
  input wire logic [3:0] sync_fault_i,
  input wire logic sync_check_en_i,
  input wire logic [7:0] alert_mask_i,
  input wire logic [15:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic cmd_hit_o,
  input wire logic ivc_set_o,
  input wire logic vendor_summary_o,
  input wire logic alert_req_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic rd;
  logic known;
  assign rd = cmd_valid_i && !cmd_write_i;
  assign known = cmd_code_i inside {8'h7f, 8'h80, 8'h88};
  // Set beats clear, so a clear is only judged when no source fires
  sequence s_quiet;
    !(|{output_restart_event_i, back_channel_fault_i, sync_fault_i}) && !sync_check_en_i &&
      !(trim_check_bad_i || store_checksum_bad_i || strap_detect_bad_i);
  endsequence
  sequence s_vclr;
    cmd_valid_i && cmd_write_i && cmd_code_i == 8'h80 && phase_i == 8'hff && cmd_wdata_i == 8'h8e;
  endsequence
  property p_rd; rd && known |=> rvalid_o && cmd_hit_o; endproperty
  property p_unk; cmd_valid_i && !known |=> !cmd_hit_o && !rvalid_o; endproperty
  property p_ivc; cmd_valid_i && cmd_write_i && cmd_code_i == 8'h88 |=> ivc_set_o && !rvalid_o;
  endproperty
  property p_oth; rd && cmd_code_i == 8'h7f |=> rdata_o[15:1] == 15'h0; endproperty
  property p_ven; rd && cmd_code_i == 8'h80 |=> rdata_o[15:8] == 8'h0 && rdata_o[5:4] == 2'h0 &&
    !rdata_o[0]; endproperty
  property p_self; rd && cmd_code_i == 8'h80 && phase_i == 8'hff && self_check_busy_i |=> rdata_o[6];
  endproperty
  property p_evt; output_restart_event_i[0] && phase_i == 8'hff && !alert_mask_i[3] |=>
    vendor_summary_o && alert_req_o; endproperty
  property p_mask; (alert_mask_i == 8'h8e) [*2] |-> !alert_req_o; endproperty
  property p_clr; clear_faults_i ##0 s_quiet |=> !vendor_summary_o && !alert_req_o; endproperty
  property p_w1c; s_vclr ##0 s_quiet |=> !vendor_summary_o; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  a_unk: assert property (p_unk) else $error("unknown code answered");
  a_ivc: assert property (p_ivc) else $error("no invalid command flag");
  a_oth: assert property (p_oth) else $error("other status high bits set");
  a_ven: assert property (p_ven) else $error("unsupported bits set");
  a_self: assert property (p_self) else $error("live busy bit low");
  a_evt: assert property (p_evt) else $error("summary or alert missing");
  a_mask: assert property (p_mask) else $error("masked flag alerts");
  a_clr: assert property (p_clr) else $error("clear faults left flags");
  a_w1c: assert property (p_w1c) else $error("write one left flags");
endmodule : psvt_regs_checker
bind psvt_regs psvt_regs_checker chk (.clk_i, .rst_n_i, .cmd_valid_i, .cmd_write_i,
  .cmd_code_i, .cmd_wdata_i, .phase_i, .clear_faults_i, .trim_check_bad_i,
  .store_checksum_bad_i, .strap_detect_bad_i, .self_check_busy_i, .output_restart_event_i,
  .back_channel_fault_i, .sync_fault_i, .sync_check_en_i, .alert_mask_i, .rdata_o,
  .rvalid_o, .cmd_hit_o, .ivc_set_o, .vendor_summary_o, .alert_req_o);

/* File: tb/testbench.sv */
// Self-checking bench for psvt_regs driven by the host model.
// Assumes a short refresh period so voltage captures happen quickly.
`timescale 1ns/1ps
module testbench;
  import psvt_pkg::*;
  localparam int REFRESH = 20;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [15:0] ev = '0;
  logic sync_clk_i = 1'b0;
  logic run_link = 1'b1;
  logic sync_check_en_i = 1'b0;
  logic self_check_busy_i = 1'b0;
  logic other_alert = 1'b0;
  logic [NDEV-1:0] follower_expected_i = '0;
  logic [NDEV-1:0] follower_responded_i = '0;
  logic [7:0] alert_mask_i = '0;
  logic [NDEV-1:0][15:0] power_input_rail_i = {16'hd321, 16'hd2a0, 16'hca80, 16'hd180};
  logic cmd_valid_i, cmd_write_i, rvalid_o, cmd_hit_o, ivc_set_o;
  logic other_summary_o, vendor_summary_o, alert_req_o;
  logic [7:0] cmd_code_i, cmd_wdata_i, phase_i;
  logic [15:0] rdata_o, q;
  int n_errors = 0;
  int comparisons = 0;
  wire logic clear_faults_i = ev[15];
  wire logic strap_detect_bad_i = ev[14];
  wire logic store_checksum_bad_i = ev[13];
  wire logic trim_check_bad_i = ev[12];
  wire logic [3:0] output_restart_event_i = ev[11:8];
  wire logic [3:0] back_channel_fault_i = ev[7:4];
  wire logic [3:0] sync_fault_i = ev[3:0];
  // Shared alert line: our own request or another device on the bus
  wire logic alert_line_n_i = ~(alert_req_o | other_alert);
  psvt_regs #(.VIN_REFRESH_CYC(REFRESH)) dut (.clk_i, .rst_n_i, .cmd_valid_i, .cmd_write_i,
    .cmd_code_i, .cmd_wdata_i, .phase_i, .clear_faults_i, .trim_check_bad_i,
    .store_checksum_bad_i, .strap_detect_bad_i, .self_check_busy_i, .follower_expected_i,
    .follower_responded_i, .output_restart_event_i, .back_channel_fault_i, .sync_fault_i,
    .sync_clk_i, .sync_check_en_i, .alert_line_n_i, .alert_mask_i, .power_input_rail_i,
    .rdata_o, .rvalid_o, .cmd_hit_o, .ivc_set_o, .other_summary_o, .vendor_summary_o,
    .alert_req_o);
  psvt_host host (.clk_i, .rdata_i(rdata_o), .rvalid_i(rvalid_o), .cmd_valid_o(cmd_valid_i),
    .cmd_write_o(cmd_write_i), .cmd_code_o(cmd_code_i), .cmd_wdata_o(cmd_wdata_i),
    .phase_o(phase_i));
  initial forever #2 clk_i = ~clk_i;
  initial forever #80 if (run_link) sync_clk_i = ~sync_clk_i;
  task automatic rd(input logic [7:0] c, input logic [7:0] p, input logic [15:0] e);
    host.xfer(1'b0, c, 8'h00, p, q);
    comparisons++;
    if (q !== e) begin
      n_errors++;
      $display("[ERR] %0t code %h got %h exp %h", $time, c, q, e);
    end
    // The summary bit must follow the other-status bit it covers
    if (c == 8'h7f) begin
      comparisons++;
      if (other_summary_o !== e[0]) begin
        n_errors++;
        $display("[ERR] %0t summary %b exp %b", $time, other_summary_o, e[0]);
      end
    end
  endtask : rd
  task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic [7:0] p);
    host.xfer(1'b1, c, d, p, q);
  endtask : wr
  task automatic pulse(input logic [15:0] v);
    @(posedge clk_i);
    ev <= v;
    @(posedge clk_i);
    ev <= '0;
  endtask : pulse
  task automatic close_out;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  initial begin
    #40000;
    n_errors++;
    close_out();
  end
  initial begin
    logic [7:0] p;
    logic [7:0] b;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(8'h7f, 8'hff, 16'h0000);
    rd(8'h80, 8'hff, 16'h0000);
    rd(8'h42, 8'hff, 16'hdead);
    repeat (REFRESH + 4) @(posedge clk_i);
    for (int d = 0; d < NDEV; d++) rd(8'h88, 8'(d), power_input_rail_i[d]);
    rd(8'h88, 8'hff, power_input_rail_i[CTRL_DEV]);
    rd(8'h88, 8'h07, 16'h0000);
    wr(8'h88, 8'h12, 8'hff);
    @(posedge clk_i);
    power_input_rail_i[1] <= 16'hd2c0;
    repeat (REFRESH + 2) @(posedge clk_i);
    rd(8'h88, 8'h01, 16'hd2c0);
    $display("test voltage done");
    for (int d = 0; d < 2; d++) begin
      for (int k = 0; k < 3; k++) begin
        p = d ? 8'h01 : 8'hff;
        b = 8'h08 >> k;
        rd(8'h80, p, 16'h0000);
        pulse(16'(1 << (8 - 4 * k + d)));
        rd(8'h80, p, {8'h00, b});
        rd(8'h80, 8'h02, 16'h0000);
        wr(8'h80, b, p);
        rd(8'h80, p, 16'h0000);
      end
      pulse(16'(1 << (12 + d)));
      rd(8'h80, 8'hff, 16'h0080);
      wr(8'h80, 8'h80, 8'hff);
      rd(8'h80, 8'hff, 16'h0000);
      pulse(16'h4000);
      rd(8'h80, 8'hff, 16'h0080);
      wr(8'h80, 8'hff, 8'hff);
      rd(8'h80, 8'hff, 16'h0000);
    end
    $display("test flags done");
    @(posedge clk_i);
    self_check_busy_i <= 1'b1;
    wr(8'h80, 8'h40, 8'hff);
    rd(8'h80, 8'hff, 16'h0040);
    @(posedge clk_i);
    {self_check_busy_i, follower_expected_i, follower_responded_i} <= 9'h0c4;
    rd(8'h80, 8'hff, 16'h0040);
    @(posedge clk_i);
    follower_responded_i <= 4'he;
    rd(8'h80, 8'hff, 16'h0000);
    $display("test live done");
    wr(8'h7f, 8'h01, 8'hff);
    rd(8'h7f, 8'hff, 16'h0000);
    @(posedge clk_i);
    alert_mask_i <= 8'h8e;
    pulse(16'h0100);
    rd(8'h7f, 8'hff, 16'h0000);
    rd(8'h80, 8'hff, 16'h0008);
    pulse(16'h8000);
    rd(8'h80, 8'hff, 16'h0000);
    @(posedge clk_i);
    {alert_mask_i, other_alert} <= 9'h001;
    repeat (3) @(posedge clk_i);
    pulse(16'h0010);
    rd(8'h7f, 8'hff, 16'h0000);
    pulse(16'h8000);
    other_alert <= 1'b0;
    repeat (3) @(posedge clk_i);
    pulse(16'h0010);
    rd(8'h7f, 8'h03, 16'h0001);
    wr(8'h80, 8'h8e, 8'hff);
    $display("test alert done");
    @(posedge clk_i);
    sync_check_en_i <= 1'b1;
    repeat (300) @(posedge clk_i);
    rd(8'h80, 8'hff, 16'h0000);
    @(posedge clk_i);
    run_link <= 1'b0;
    repeat (300) @(posedge clk_i);
    rd(8'h80, 8'hff, 16'h0002);
    $display("test sync done");
    close_out();
  end
endmodule : testbench
